//--- fpu_exc_xfer.v
// fp exception detector, control/status register and data transfer unit
`timescale 1ns/10ps
`default_nettype none
`include "fpu_exc_defs.vh"
module fpu_exc_xfer
(
  // clock and reset
  input  wire        sys_clk_in,
  input  wire        sys_rst_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // completed arithmetic operation
  input  wire        op_valid_in,
  input  wire        op_unimpl_in,
  input  wire        op_invalid_in,
  input  wire        op_div_in,
  input  wire        dividend_zero_in,
  input  wire        dividend_inf_in,
  input  wire        dividend_nan_in,
  input  wire        divisor_zero_in,
  input  wire        op_ovf_in,
  input  wire        op_tiny_in,
  input  wire        op_inexact_in,
  input  wire        op_sign_in,
  input  wire        op_dbl_in,
  input  wire [4:0]  op_dest_in,
  input  wire [63:0] op_result_in,
  output reg  [5:0]  cond_out,
  output reg  [63:0] result_out,
  output reg         op_done_out,
  output reg         trap_out,
  // transfer request
  input  wire        xfer_valid_in,
  input  wire [2:0]  xfer_kind_in,
  input  wire        xfer_dword_in,
  input  wire        xfer_indexed_in,
  input  wire        big_endian_in,
  input  wire [31:0] base_in,
  input  wire [15:0] offset_in,
  input  wire [31:0] index_in,
  input  wire [4:0]  freg_in,
  input  wire [63:0] int_data_in,
  output reg  [63:0] int_data_out,
  output reg         xfer_busy_out,
  output reg         xfer_done_out,
  output reg         addr_err_out,
  // memory port, lane i holds the byte at address+i
  input  wire        mem_ack_in,
  input  wire [63:0] mem_rdata_in,
  output reg         mem_req_out,
  output reg         mem_we_out,
  output reg         mem_dword_out,
  output reg  [31:0] mem_addr_out,
  output reg  [63:0] mem_wdata_out,
  // source use check for the load interlock
  input  wire        use_valid_in,
  input  wire [4:0]  use_reg_in,
  output reg         use_grant_out
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  localparam X_IDLE = 1'b0;          // waiting for a transfer
  localparam X_MEM  = 1'b1;          // memory access in flight
  reg [63:0] fpr [0:31];             // general registers
  reg [31:0] csr;                    // control register set
  reg        xstate;                 // transfer state
  reg        ld_dword;               // load in flight is a dword
  reg        ld_big;                 // load in flight byte order
  reg        pend_valid;             // load result outstanding
  reg [4:0]  pend_reg;               // register awaiting it
  reg [5:0]  next_cond;              // conditions of this op
  reg [63:0] next_res;               // delivered result
  reg [31:0] next_csr;               // csr after all writers
  reg        op_trap;                // this op traps precisely
  reg        dz;                     // raw divide by zero
  reg        unf;                    // raw underflow
  reg        inx;                    // raw inexact
  wire [31:0] ea = base_in + (xfer_indexed_in ? index_in : {{16{offset_in[15]}}, offset_in});
  wire        misaligned = xfer_dword_in ? (ea[2:0] != 3'h0) : (ea[1:0] != 2'h0); // not naturally aligned
  wire        take = xfer_valid_in & (xstate == X_IDLE); // accepted when idle
  wire        apb_acc = psel_in & penable_in & pready_out; // apb transfer completes
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  // memory lanes to register value and back; its own inverse
  function [63:0] order;
    input [63:0] d;
    input        dw;
    input        big;
    integer      i;
    begin
      order = 64'h0;
      for (i = 0; i < 8; i = i + 1)
      begin
        if (dw | (i < 4))
          order[8*i +: 8] = big ? d[8*((dw ? 7 : 3) - i) +: 8] : d[8*i +: 8];
      end
    end
  endfunction
  // signed infinity or largest finite in either format
  function [63:0] special;
    input dbl;
    input sgn;
    input inf;
    begin
      special = dbl ? ((inf ? `DP_INF : `DP_MAX) | {sgn, 63'h0})
                    : {32'h0, (inf ? `SP_INF : `SP_MAX) | {sgn, 31'h0}};
    end
  endfunction
  // ---------------------------------------------
  // exception detection
  // ---------------------------------------------
  // one priority chain keeps one condition per op; inexact may join overflow or underflow
  always @*
  begin
    dz  = op_div_in & divisor_zero_in & ~dividend_zero_in & ~dividend_inf_in & ~dividend_nan_in;
    // tiny is judged on the rounded unbounded-exponent value
    unf = op_tiny_in & (csr[`EN_LO + `C_UNF] | op_inexact_in);
    inx = op_inexact_in | (op_ovf_in & ~csr[`EN_LO + `C_OVF]);
    next_cond = 6'h00;
    if (op_unimpl_in)
      next_cond[`C_UNI] = 1'b1;
    else if (op_invalid_in | (op_div_in & divisor_zero_in & dividend_zero_in))
      next_cond[`C_INV] = 1'b1;
    else if (dz)
      next_cond[`C_DZ] = 1'b1;
    else
    begin
      next_cond[`C_OVF] = op_ovf_in;
      next_cond[`C_UNF] = unf & ~op_ovf_in;
      next_cond[`C_INX] = inx;
    end
    // default results for untrapped conditions
    next_res = op_result_in;
    if (next_cond[`C_INV])
      next_res = op_dbl_in ? `DP_QNAN : {32'h0, `SP_QNAN};
    else if (op_div_in & divisor_zero_in & ~dividend_zero_in & ~dividend_nan_in)
      next_res = special(op_dbl_in, op_sign_in, 1'b1);
    else if (op_ovf_in)
    begin
      case (csr[`RM_HI:`RM_LO])
        `RM_NEAR:  next_res = special(op_dbl_in, op_sign_in, 1'b1);
        `RM_ZERO:  next_res = special(op_dbl_in, op_sign_in, 1'b0);
        `RM_PLUS:  next_res = special(op_dbl_in, op_sign_in, ~op_sign_in);
        `RM_MINUS: next_res = special(op_dbl_in, op_sign_in, op_sign_in);
        default:   next_res = op_result_in;
      endcase
    end
    op_trap = op_valid_in & (next_cond[`C_UNI] | (|(next_cond[4:0] & csr[`EN_HI:`EN_LO])));
  end
  // ---------------------------------------------
  // control and status register
  // ---------------------------------------------
  // order: apb write, then control move, then op record
  always @*
  begin
    next_csr = csr;
    if (apb_acc & pwrite_in & (paddr_in == `CSR_ADDR))
      next_csr = pwdata_in & `CSR_MASK;
    if (take & (xfer_kind_in == `XK_CTC))
      next_csr = int_data_in[31:0] & `CSR_MASK;
    if (op_valid_in)
    begin
      next_csr[`CAUSE_HI:`CAUSE_LO] = next_cond;
      // trapped ops leave flags alone; set wins over a clear
      if (~op_trap)
        next_csr[`FLAG_HI:`FLAG_LO] = next_csr[`FLAG_HI:`FLAG_LO] | next_cond[4:0];
    end
  end
  // csr, condition outputs and trap line
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      csr         <= `CSR_RST;
      cond_out    <= 6'h00;
      result_out  <= 64'h0;
      op_done_out <= 1'b0;
      trap_out    <= 1'b0;
    end
    else
    begin
      csr         <= next_csr;
      cond_out    <= op_valid_in ? next_cond : 6'h00;
      result_out  <= next_res;
      op_done_out <= op_valid_in;
      // also fires when software writes cause and enable
      trap_out    <= next_csr[`CAUSE_LO + `C_UNI]
                     | (|(next_csr[`CAUSE_HI-1:`CAUSE_LO] & next_csr[`EN_HI:`EN_LO]));
    end
  end
  // ---------------------------------------------
  // general register file
  // ---------------------------------------------
  // a trapping op writes nothing, so the handler can re-run it
  always @(posedge sys_clk_in)
  begin
    if (op_valid_in & ~op_trap)
      fpr[op_dest_in] <= next_res;
    if (take & (xfer_kind_in == `XK_MTC))
      fpr[freg_in] <= xfer_dword_in ? int_data_in : {32'h0, int_data_in[31:0]};
    if ((xstate == X_MEM) & ~mem_we_out & mem_ack_in)
      fpr[pend_reg] <= order(mem_rdata_in, ld_dword, ld_big);
  end
  // ---------------------------------------------
  // transfer path
  // ---------------------------------------------
  // accepts one transfer when idle; memory ops wait for ack
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      xstate        <= X_IDLE;
      xfer_busy_out <= 1'b0;
      xfer_done_out <= 1'b0;
      addr_err_out  <= 1'b0;
      int_data_out  <= 64'h0;
      mem_req_out   <= 1'b0;
      mem_we_out    <= 1'b0;
      mem_dword_out <= 1'b0;
      mem_addr_out  <= 32'h0;
      mem_wdata_out <= 64'h0;
      pend_valid    <= 1'b0;
      pend_reg      <= 5'h00;
    end
    else
    begin
      xfer_done_out <= 1'b0;
      addr_err_out  <= 1'b0;
      case (xstate)
        X_IDLE:
        begin
          if (take)
          begin
            case (xfer_kind_in)
              `XK_LOAD, `XK_STORE:
              begin
                if (misaligned)
                  addr_err_out <= 1'b1;
                else
                begin
                  xstate        <= X_MEM;
                  xfer_busy_out <= 1'b1;
                  mem_req_out   <= 1'b1;
                  mem_we_out    <= (xfer_kind_in == `XK_STORE);
                  mem_dword_out <= xfer_dword_in;
                  mem_addr_out  <= ea;
                  mem_wdata_out <= order(fpr[freg_in], xfer_dword_in, big_endian_in);
                  ld_dword      <= xfer_dword_in;
                  ld_big        <= big_endian_in;
                  pend_valid    <= (xfer_kind_in == `XK_LOAD);
                  pend_reg      <= freg_in;
                end
              end
              `XK_MFC:
              begin
                int_data_out  <= xfer_dword_in ? fpr[freg_in] : {32'h0, fpr[freg_in][31:0]};
                xfer_done_out <= 1'b1;
              end
              `XK_CFC:
              begin
                int_data_out  <= {32'h0, csr};
                xfer_done_out <= 1'b1;
              end
              default:
                xfer_done_out <= 1'b1;
            endcase
          end
        end
        X_MEM:
        begin
          if (mem_ack_in)
          begin
            xstate        <= X_IDLE;
            xfer_busy_out <= 1'b0;
            mem_req_out   <= 1'b0;
            mem_we_out    <= 1'b0;
            xfer_done_out <= 1'b1;
            pend_valid    <= 1'b0;
          end
        end
        default:
          xstate <= X_IDLE;
      endcase
    end
  end
  // ---------------------------------------------
  // load interlock
  // ---------------------------------------------
  // grant withheld while the named register awaits load data;
  // scheduling a delay slot still saves these stall cycles
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      use_grant_out <= 1'b0;
    else
      use_grant_out <= use_valid_in & ~(pend_valid & (pend_reg == use_reg_in)
                       & ~(mem_ack_in & ~mem_we_out));
  end
  // ---------------------------------------------
  // apb slave
  // ---------------------------------------------
  // one wait state; unmapped addresses answer with pslverr
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end
    else
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      if (psel_in & penable_in & ~pready_out)
      begin
        pready_out <= 1'b1;
        case (paddr_in)
          `CSR_ADDR:  prdata_out <= csr;
          `STAT_ADDR: prdata_out <= {24'h0, pend_reg, pend_valid, xfer_busy_out, trap_out};
          default:
          begin
            prdata_out  <= 32'h0;
            pslverr_out <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // fpu_exc_xfer
`default_nettype wire

//--- fpu_exc_defs.vh
// constants for the fp exception detector and transfer block
//
// Overview of operation
// - divide by zero: finite nonzero over zero
// - 0/0 invalid, inf/0 signed infinity
// - overflow: rounded unbounded magnitude exceeds max
// - overflow result chosen by rounding mode
// - tininess detected after rounding
// - accuracy loss detected as inexact result
// - trap off: underflow needs tiny and inexact
// - trap on: underflow whenever tiny
// - inexact also on untrapped overflow
// - unimplemented always traps, no enable
// - unimplemented trap leaves state resumable
// - transfers are raw bits, no conditions
// - general and control register sets distinct
// - word/dword data, control moves whole words
// - misaligned load or store: address error
// - lowest address names item, byte order
// - base+offset and base+index addressing
// - newer level: interlock stalls early use
// - cause and enable both set gives trap
// - one condition, inexact may join ovf/unf
`ifndef FPU_EXC_DEFS_VH
`define FPU_EXC_DEFS_VH
// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define CSR_ADDR   8'h00
`define STAT_ADDR  8'h04
`define CSR_RST    32'h0000_0000
`define CSR_MASK   32'h0003_ffff
// ---------------------------------------------
// control and status fields
// ---------------------------------------------
`define RM_HI      1
`define RM_LO      0
`define FLAG_HI    6
`define FLAG_LO    2
`define EN_HI      11
`define EN_LO      7
`define CAUSE_HI   17
`define CAUSE_LO   12
// ---------------------------------------------
// condition vector bits
// ---------------------------------------------
`define C_INX      0
`define C_UNF      1
`define C_OVF      2
`define C_DZ       3
`define C_INV      4
`define C_UNI      5
// ---------------------------------------------
// rounding modes and transfer kinds
// ---------------------------------------------
`define RM_NEAR    2'h0
`define RM_ZERO    2'h1
`define RM_PLUS    2'h2
`define RM_MINUS   2'h3
`define XK_LOAD    3'h0
`define XK_STORE   3'h1
`define XK_MFC     3'h2
`define XK_MTC     3'h3
`define XK_CTC     3'h4
`define XK_CFC     3'h5
// ---------------------------------------------
// special values
// ---------------------------------------------
`define DP_INF     64'h7ff0_0000_0000_0000
`define DP_MAX     64'h7fef_ffff_ffff_ffff
`define DP_QNAN    64'h7ff8_0000_0000_0000
`define SP_INF     32'h7f80_0000
`define SP_MAX     32'h7f7f_ffff
`define SP_QNAN    32'h7fc0_0000
`endif

//--- fpu_exc_xfer_properties.sv
// assertion checker for the fp exception and transfer block
`timescale 1ns/10ps
`default_nettype none
module fpu_exc_xfer_properties
(
  // watched ports, grouped by width
  input wire logic        sys_clk_in, sys_rst_in, op_valid_in, op_unimpl_in, op_invalid_in,
  input wire logic        op_div_in, op_ovf_in, dividend_zero_in, dividend_inf_in, dividend_nan_in,
  input wire logic        divisor_zero_in, op_done_out, trap_out, xfer_valid_in, xfer_dword_in,
  input wire logic        xfer_indexed_in, xfer_busy_out, addr_err_out, mem_req_out,
  input wire logic [5:0]  cond_out,
  input wire logic [2:0]  xfer_kind_in,
  input wire logic [31:0] base_in, index_in, mem_addr_out,
  input wire logic [15:0] offset_in
);
  // -------------------------------------------
  // helper logic
  // -------------------------------------------
  logic [31:0] ea;    // effective address of a request
  logic        mis;   // not naturally aligned
  logic        memop; // accepted load or store
  logic        pre;   // op with no higher-priority cause
  assign ea    = base_in + (xfer_indexed_in ? index_in : {{16{offset_in[15]}}, offset_in});
  assign mis   = xfer_dword_in ? (ea[2:0] != 3'h0) : (ea[1:0] != 2'h0);
  assign memop = xfer_valid_in && !xfer_busy_out && (xfer_kind_in <= 3'h1);
  assign pre   = op_valid_in && !op_unimpl_in && !op_invalid_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // -------------------------------------------
  // properties
  // -------------------------------------------
  a_op_done_next: assert property (op_valid_in |=> op_done_out)
    else $error("no completion after op");
  a_idle_quiet: assert property (!op_valid_in |=> !op_done_out && cond_out == 6'h00)
    else $error("condition without op");
  a_single_cond: assert property (op_done_out |-> $onehot0(cond_out[5:1]) && !(cond_out[0] && |cond_out[5:3]))
    else $error("illegal condition mix");
  a_divzero_set: assert property (pre && op_div_in && divisor_zero_in && !dividend_zero_in && !dividend_inf_in
    && !dividend_nan_in |=> cond_out == 6'h08)
    else $error("divide by zero missed");
  a_zero_zero: assert property (op_valid_in && !op_unimpl_in && op_div_in && divisor_zero_in && dividend_zero_in
    |=> cond_out == 6'h10)
    else $error("zero over zero not invalid");
  a_inf_zero: assert property (pre && op_div_in && divisor_zero_in && dividend_inf_in |=> !cond_out[3])
    else $error("inf over zero flagged");
  a_ovf_raised: assert property (pre && op_ovf_in && !(op_div_in && divisor_zero_in)
    |=> cond_out[2] && !cond_out[1])
    else $error("overflow missed");
  a_unimpl_trap: assert property (op_valid_in && op_unimpl_in |=> cond_out == 6'h20 && trap_out)
    else $error("unimplemented did not trap");
  a_misalign_err: assert property (memop && mis |=> addr_err_out && !mem_req_out)
    else $error("misaligned access made");
  a_req_addr: assert property (memop && !mis |=> mem_req_out && mem_addr_out == $past(ea))
    else $error("wrong access address");
endmodule // fpu_exc_xfer_properties
bind fpu_exc_xfer fpu_exc_xfer_properties u_props (.sys_clk_in, .sys_rst_in, .op_valid_in, .op_unimpl_in,
  .op_invalid_in, .op_div_in, .op_ovf_in, .dividend_zero_in, .dividend_inf_in, .dividend_nan_in,
  .divisor_zero_in, .op_done_out, .trap_out, .xfer_valid_in, .xfer_dword_in, .xfer_indexed_in,
  .xfer_busy_out, .addr_err_out, .mem_req_out, .cond_out, .xfer_kind_in, .base_in, .index_in,
  .mem_addr_out, .offset_in);
`default_nettype wire

//--- fpu_mem_model.sv
// memory stand-in on the far side of the transfer port
`timescale 1ns/10ps
`default_nettype none
module fpu_mem_model
(
  // clock, request and answer
  input  wire logic        clk_in, rst_in, req_in, we_in, dword_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [63:0] wdata_in,
  input  wire logic [3:0]  delay_in,
  output var  logic        ack_out,
  output var  logic [63:0] rdata_out
);
  logic [7:0] mem [0:255]; // address wraps, enough for the bench
  int         wait_cnt;    // cycles already stalled
  // answer after delay_in stall cycles; data toggles outside an answer
  always @(posedge clk_in)
  begin
    ack_out   <= 1'b0;
    rdata_out <= ~rdata_out;
    if (rst_in)
    begin
      wait_cnt  <= 0;
      rdata_out <= 64'h0f0f_0f0f_0f0f_0f0f;
    end
    else if (req_in && !ack_out)
    begin
      if (wait_cnt < delay_in)
        wait_cnt <= wait_cnt + 1;
      else
      begin
        wait_cnt <= 0;
        ack_out  <= 1'b1;
        // lane i is the byte at address plus i
        for (int i = 0; i < 8; i++)
        begin
          if (we_in && (i < 4 || dword_in))
            mem[(addr_in + i) & 255] <= wdata_in[8*i +: 8];
          rdata_out[8*i +: 8] <= mem[(addr_in + i) & 255];
        end
      end
    end
  end
endmodule // fpu_mem_model
`default_nettype wire

//--- fpu_exc_xfer_tb_top.sv
// self-checking bench for the fp exception and transfer block
`timescale 1ns/10ps
`default_nettype none
`include "fpu_exc_defs.vh"
module fpu_exc_xfer_tb_top;
  // -------------------------------------------
  // nets and bench state
  // -------------------------------------------
  logic sys_clk_in = 0, sys_rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, pready_out, pslverr_out;
  logic op_valid_in = 0, op_unimpl_in = 0, op_invalid_in = 0, op_div_in = 0, dividend_zero_in = 0;
  logic dividend_inf_in = 0, dividend_nan_in = 0, divisor_zero_in = 0, op_ovf_in = 0, op_tiny_in = 0;
  logic op_inexact_in = 0, op_sign_in = 0, op_dbl_in = 0, op_done_out, trap_out, use_valid_in = 0;
  logic xfer_valid_in = 0, xfer_dword_in = 0, xfer_indexed_in = 0, big_endian_in = 0, use_grant_out;
  logic xfer_busy_out, xfer_done_out, addr_err_out, mem_ack_in, mem_req_out, mem_we_out, mem_dword_out;
  logic [7:0]  paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, base_in = 0, index_in = 0, mem_addr_out, rd, b, x, ea, w;
  logic [4:0]  op_dest_in = 0, freg_in = 0, use_reg_in = 0, en = 0, f, g;
  logic [63:0] op_result_in = 0, result_out, int_data_in = 0, int_data_out, mem_rdata_in, mem_wdata_out;
  logic [63:0] xd, d, rf, rg, m;
  logic [5:0]  cond_out;
  logic [2:0]  xfer_kind_in = 0;
  logic [15:0] offset_in = 0, o;
  logic [3:0]  mem_delay = 0;
  logic [1:0]  rm = 0;
  logic        err, dw, be, ix;
  int          n_fail = 0, cmp_count = 0, k, n;
  always #5 sys_clk_in = ~sys_clk_in;
  fpu_exc_xfer u_dut (.sys_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .op_valid_in, .op_unimpl_in, .op_invalid_in, .op_div_in,
    .dividend_zero_in, .dividend_inf_in, .dividend_nan_in, .divisor_zero_in, .op_ovf_in, .op_tiny_in,
    .op_inexact_in, .op_sign_in, .op_dbl_in, .op_dest_in, .op_result_in, .cond_out, .result_out,
    .op_done_out, .trap_out, .xfer_valid_in, .xfer_kind_in, .xfer_dword_in, .xfer_indexed_in,
    .big_endian_in, .base_in, .offset_in, .index_in, .freg_in, .int_data_in, .int_data_out,
    .xfer_busy_out, .xfer_done_out, .addr_err_out, .mem_ack_in, .mem_rdata_in, .mem_req_out,
    .mem_we_out, .mem_dword_out, .mem_addr_out, .mem_wdata_out, .use_valid_in, .use_reg_in, .use_grant_out);
  fpu_mem_model u_mem (.clk_in(sys_clk_in), .rst_in(sys_rst_in), .req_in(mem_req_out), .we_in(mem_we_out),
    .dword_in(mem_dword_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .delay_in(mem_delay),
    .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
  // -------------------------------------------
  // compare, verdict and bus tasks
  // -------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bail(input string what);
    n_fail++;
    $display("[FAIL] %0t %s timed out", $time, what);
    tally_and_finish();
  endtask
  // apb master: setup, then access held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge sys_clk_in);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    for (i = 0; i < 16 && pready_out !== 1'b1; i++)
      @(posedge sys_clk_in);
    if (i == 16)
      bail("apb");
    rd  = prdata_out;
    err = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
  endtask
  // signed infinity or largest finite of the format
  function automatic logic [63:0] sgn(input logic dbl, input logic s, input logic inf);
    if (dbl)
      return (inf ? `DP_INF : `DP_MAX) | {s, 63'h0};
    return {32'h0, (inf ? `SP_INF : `SP_MAX) | {s, 31'h0}};
  endfunction
  // one random completed op, checked against the priority model
  task automatic op_rand;
    logic uni, inv, dv, z0, di, dn, vz, ov, ti, ix1, s, dbl, trp;
    logic [5:0] c;
    logic [63:0] r, ex;
    {uni, inv, dv, z0, di, dn, vz, ov, ti, ix1, s, dbl} = 12'($urandom);
    uni = uni && ($urandom % 6 == 0);
    inv = inv && ($urandom % 3 == 0);
    di = di && !z0;
    dn = dn && !z0 && !di;
    if (dv && vz)
      {ov, ti, ix1} = 3'h0; // a divide by zero is exact
    r = {$urandom, $urandom};
    @(posedge sys_clk_in);
    {op_valid_in, op_unimpl_in, op_invalid_in, op_div_in, dividend_zero_in, dividend_inf_in} <= {1'b1, uni, inv, dv, z0, di};
    {dividend_nan_in, divisor_zero_in, op_ovf_in, op_tiny_in, op_inexact_in} <= {dn, vz, ov, ti, ix1};
    {op_sign_in, op_dbl_in, op_result_in, op_dest_in} <= {s, dbl, r, 5'($urandom)};
    @(posedge sys_clk_in);
    op_valid_in <= 1'b0;
    if (uni) c = 6'h20;
    else if (inv || (dv && vz && z0)) c = 6'h10;
    else if (dv && vz && !di && !dn) c = 6'h08;
    else c = {3'h0, ov, ti && !ov && (ix1 || en[1]), ix1 || (ov && !en[2])};
    trp = uni || |(c[4:0] & en);
    m = dbl ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_ffff_ffff;
    if (c[4]) ex = dbl ? `DP_QNAN : {32'h0, `SP_QNAN};
    else if (c[3] || (dv && vz && di)) ex = sgn(dbl, s, 1'b1);
    else if (c[2]) ex = sgn(dbl, s, rm == 2'h0 || (rm == 2'h2 && !s) || (rm == 2'h3 && s));
    else ex = r;
    @(posedge sys_clk_in);
    chk(op_done_out, 1, "op done");
    chk(cond_out, c, "conditions");
    chk(trap_out, trp, "trap");
    if (!trp)
      chk(result_out & m, ex & m, "result");
  endtask
  // one transfer request, waits for done or address error
  task automatic xfer(input logic [2:0] kd, input logic [4:0] rg_sel, input logic [63:0] dat, input logic exp_err);
    int i;
    @(posedge sys_clk_in);
    {xfer_valid_in, xfer_kind_in, xfer_dword_in, xfer_indexed_in, big_endian_in} <= {1'b1, kd, dw, ix, be};
    {base_in, offset_in, index_in, freg_in, int_data_in} <= {b, o, x, rg_sel, dat};
    mem_delay <= 4'($urandom % 4);
    @(posedge sys_clk_in);
    xfer_valid_in <= 1'b0;
    for (i = 0; i < 40 && xfer_done_out !== 1'b1 && addr_err_out !== 1'b1; i++)
      @(posedge sys_clk_in);
    if (i == 40)
      bail("transfer");
    chk(addr_err_out, exp_err, "address error");
    chk(cond_out, 6'h00, "transfer conditions");
    xd = int_data_out;
  endtask
  // -------------------------------------------
  // main sequence
  // -------------------------------------------
  initial
  begin
    rd = $urandom(32'h2d45);
    repeat (6) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    apb(1'b0, `CSR_ADDR, 32'h0);
    chk(rd, `CSR_RST, "csr reset value");
    apb(1'b1, `CSR_ADDR, 32'hffff_ffff);
    apb(1'b0, `CSR_ADDR, 32'h0);
    chk(rd, `CSR_MASK, "csr readback");
    chk(trap_out, 1, "trap by csr write");
    apb(1'b1, `CSR_ADDR, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(err, 1, "unmapped slave error");
    // random ops, rounding mode and enables changed now and then
    for (k = 0; k < 400; k++)
    begin
      if (k % 25 == 0)
      begin
        {rm, en} = 7'($urandom);
        apb(1'b1, `CSR_ADDR, {20'h0, en, 5'h00, rm});
      end
      op_rand();
    end
    // move in, store, load back in the other byte order, move out
    for (k = 0; k < 24; k++)
    begin
      {dw, be, ix} = 3'(k);
      {f, o, x, d} = {5'($urandom), 16'($urandom), $urandom, $urandom, $urandom};
      g = ~f;
      ea = $urandom & (dw ? 32'hffff_fff8 : 32'hffff_fffc);
      b = ea - (ix ? x : {{16{o[15]}}, o});
      n = dw ? 8 : 4;
      m = dw ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_ffff_ffff;
      rf = d & m;
      rg = 64'h0;
      xfer(3'h3, f, d, 1'b0);
      xfer(3'h1, f, 64'h0, 1'b0);
      for (int i = 0; i < n; i++)
      begin
        chk(u_mem.mem[(ea + i) & 255], rf[8*(be ? n-1-i : i) +: 8], "stored byte");
        rg[8*(be ? i : n-1-i) +: 8] = rf[8*(be ? n-1-i : i) +: 8];
      end
      be = !be;
      xfer(3'h0, g, 64'h0, 1'b0);
      xfer(3'h2, g, 64'h0, 1'b0);
      chk(xd & m, rg, "loaded raw bits");
      b = b + (dw ? 32'h4 : 32'h2);
      xfer({2'b00, k[3]}, f, 64'h0, 1'b1);
    end
    // control word moves both ways
    w = $urandom & 32'h0000_0fff;
    xfer(3'h4, 5'h0, {32'h0, w}, 1'b0);
    xfer(3'h5, 5'h0, 64'h0, 1'b0);
    chk(xd[31:0], w, "control read by move");
    apb(1'b0, `CSR_ADDR, 32'h0);
    chk(rd, w, "control read by bus");
    // slow load: a use of its target stalls, others do not
    @(posedge sys_clk_in);
    {xfer_valid_in, xfer_kind_in, xfer_dword_in, xfer_indexed_in, base_in, offset_in} <= {1'b1, 3'h0, 2'h0, 32'h40, 16'h0};
    {freg_in, use_valid_in, use_reg_in, mem_delay} <= {5'h05, 1'b1, 5'h05, 4'h7};
    @(posedge sys_clk_in);
    xfer_valid_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk(use_grant_out, 0, "stall on pending load");
    use_reg_in <= 5'h06;
    repeat (2) @(posedge sys_clk_in);
    chk(use_grant_out, 1, "other register free");
    use_reg_in <= 5'h05;
    for (k = 0; k < 40 && xfer_done_out !== 1'b1; k++)
      @(posedge sys_clk_in);
    if (k == 40)
      bail("interlock");
    repeat (2) @(posedge sys_clk_in);
    chk(use_grant_out, 1, "grant after data");
    use_valid_in <= 1'b0;
    tally_and_finish();
  end
endmodule // fpu_exc_xfer_tb_top
`default_nettype wire
